// ### rtl/fmc_pkg.sv
// Constants for the fan smoothing / core sleep / override configuration pair.
// Assumes a 25 MHz core clock and an internal byte-wide register port.
// Function
// R01: slow bit 0 quadruples remote-one smoothing
// R02: slow bit 1 quadruples local smoothing
// R03: slow bit 2 quadruples remote-two smoothing
// R04: core low on standby sets status bit
// R05: core low raises alert when enabled
// R06: core low suspends processor-hot monitoring
// R07: recovery re-enables monitoring, then spin-up
// R08: extra-stretch bit adds 39.2 percent
// R09: lock makes both registers read-only except the full-speed bit
// R10: hysteresis on by default, bit disables
// R11: full-speed bit forces maximum duty
// R12: full-speed bit writable even when locked
// R13: firmware sets power-display flag; stored only
// R14: spin-up style holds outputs whole timeout
// R15: timeout-disable bit turns bus timeout off
// R16: release bus after 35 ms idle
// R17: host never writes reserved upper bits
// R18: reserved bits read zero, ignore writes
package fmc_pkg;

    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam logic [7:0] FMC_CFG6_ADDR  = 8'h10;
    localparam logic [7:0] FMC_CFG7_ADDR  = 8'h11;
    localparam logic [7:0] FMC_CFG6_RESET = 8'h00;
    localparam logic [7:0] FMC_CFG7_RESET = 8'h00;
    localparam logic [7:0] FMC_CFG6_MASK  = 8'hc7;
    localparam logic [7:0] FMC_CFG7_MASK  = 8'h1f;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int FMC_SLOW_REMOTE1 = 0;
    localparam int FMC_SLOW_LOCAL   = 1;
    localparam int FMC_SLOW_REMOTE2 = 2;
    localparam int FMC_CORE_SLEEP   = 6;
    localparam int FMC_EXTRA_SLOW   = 7;
    localparam int FMC_HYST_DIS     = 0;
    localparam int FMC_FULL_SPEED   = 1;
    localparam int FMC_PWR_DISPLAY  = 2;
    localparam int FMC_SPIN_STYLE   = 3;
    localparam int FMC_TO_DIS       = 4;

    // ----------------------------------------------------------------
    // smoothing arithmetic
    // ----------------------------------------------------------------
    localparam int FMC_SLOW_SHIFT    = 2;
    // 401/1024 = 0.3916, nearest fraction of that form to 0.392
    localparam int FMC_EXTRA_NUM     = 401;
    localparam int FMC_EXTRA_SHIFT   = 10;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam longint FMC_CLK_PERIOD_NS  = 40;
    localparam longint FMC_BUS_TIMEOUT_NS = 35000000;
    localparam int     FMC_BUS_TIMEOUT_CYC =
        int'((FMC_BUS_TIMEOUT_NS + FMC_CLK_PERIOD_NS - 1) / FMC_CLK_PERIOD_NS);
    localparam int     FMC_TIMEOUT_W = 20;

    typedef enum logic [2:0] {
        FMC_ST_RUN   = 3'b001,
        FMC_ST_SLEEP = 3'b010,
        FMC_ST_SPIN  = 3'b100
    } fmc_state_t;

endpackage

// ### rtl/fmc_config_six_seven.sv
// Configuration registers 6 and 7 with the logic they steer directly.
// Assumes the two-wire engine presents a byte register port on clk, and the
// fan, comparator and alert logic around it are on the same clock.
module fmc_config_six_seven
    import fmc_pkg::*;
#(
    parameter int SMOOTH_W    = 16,
    parameter int TIMEOUT_CYC = FMC_BUS_TIMEOUT_CYC
) (
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    input  wire logic [7:0]            reg_addr,
    input  wire logic                  reg_wr_en,
    input  wire logic [7:0]            reg_wr_data,
    input  wire logic                  reg_rd_en,
    output logic      [7:0]            reg_rd_data,
    output logic                       reg_hit,
    input  wire logic                  lock,
    input  wire logic [SMOOTH_W-1:0]   base_time_remote1,
    input  wire logic [SMOOTH_W-1:0]   base_time_local,
    input  wire logic [SMOOTH_W-1:0]   base_time_remote2,
    output logic      [SMOOTH_W+2:0]   smooth_time_remote1,
    output logic      [SMOOTH_W+2:0]   smooth_time_local,
    output logic      [SMOOTH_W+2:0]   smooth_time_remote2,
    input  wire logic                  standby_supply_pin,
    input  wire logic [7:0]            core_voltage_reading,
    input  wire logic [7:0]            core_voltage_low_limit,
    input  wire logic                  core_low_alert_enable,
    input  wire logic                  spinup_done,
    output logic                       core_low_status_set,
    output logic                       core_low_alert,
    output logic                       processor_hot_monitor_en,
    output logic                       spinup_request,
    output logic                       overtemp_hysteresis_en,
    output logic                       all_fans_full_speed,
    output logic                       power_display_flag,
    output logic                       spinup_pulse_count_disable,
    input  wire logic                  scl_pin,
    input  wire logic                  sda_pin,
    input  wire logic                  bus_addressed,
    output logic                       bus_release
);

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    logic [7:0] cfg6;
    logic [7:0] cfg7;
    wire        wr6 = reg_wr_en && reg_addr == FMC_CFG6_ADDR;
    wire        wr7 = reg_wr_en && reg_addr == FMC_CFG7_ADDR;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg6 <= FMC_CFG6_RESET;
        end else if (wr6 && !lock) begin                         // R09
            cfg6 <= reg_wr_data & FMC_CFG6_MASK;                 // R18
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg7 <= FMC_CFG7_RESET;
        end else if (wr7) begin
            if (!lock) begin                                     // R09
                cfg7 <= reg_wr_data & FMC_CFG7_MASK;             // R17 R18
            end else begin
                cfg7[FMC_FULL_SPEED] <= reg_wr_data[FMC_FULL_SPEED]; // R12
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rd_data <= 8'h00;
            reg_hit     <= 1'b0;
        end else begin
            reg_hit <= (reg_rd_en || reg_wr_en)
                       && (reg_addr == FMC_CFG6_ADDR || reg_addr == FMC_CFG7_ADDR);
            if (reg_rd_en) begin
                // unmapped addresses answer zero
                unique case (reg_addr)
                    FMC_CFG6_ADDR: reg_rd_data <= cfg6;
                    FMC_CFG7_ADDR: reg_rd_data <= cfg7;
                    default:       reg_rd_data <= 8'h00;
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // plain control bits
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            overtemp_hysteresis_en     <= 1'b1;
            all_fans_full_speed        <= 1'b0;
            power_display_flag         <= 1'b0;
            spinup_pulse_count_disable <= 1'b0;
        end else begin
            overtemp_hysteresis_en     <= !cfg7[FMC_HYST_DIS];   // R10
            all_fans_full_speed        <= cfg7[FMC_FULL_SPEED];  // R11
            power_display_flag         <= cfg7[FMC_PWR_DISPLAY]; // R13
            spinup_pulse_count_disable <= cfg7[FMC_SPIN_STYLE];  // R14
        end
    end

    // ----------------------------------------------------------------
    // smoothing times
    // ----------------------------------------------------------------
    function automatic logic [SMOOTH_W+2:0] stretch(
        input logic [SMOOTH_W-1:0] base,
        input logic                slow,
        input logic                extra
    );
        logic [SMOOTH_W+2:0]  t;
        logic [SMOOTH_W+12:0] prod;
        t    = {3'b000, base};
        if (slow) begin
            t = t << FMC_SLOW_SHIFT;
        end
        prod = t * (SMOOTH_W+13)'(FMC_EXTRA_NUM);
        if (extra) begin
            t = t + (SMOOTH_W+3)'(prod >> FMC_EXTRA_SHIFT);
        end
        return t;
    endfunction

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            smooth_time_remote1 <= '0;
            smooth_time_local   <= '0;
            smooth_time_remote2 <= '0;
        end else begin
            smooth_time_remote1 <= stretch(base_time_remote1, cfg6[FMC_SLOW_REMOTE1],
                                           cfg6[FMC_EXTRA_SLOW]);   // R01 R08
            smooth_time_local   <= stretch(base_time_local, cfg6[FMC_SLOW_LOCAL],
                                           cfg6[FMC_EXTRA_SLOW]);   // R02 R08
            smooth_time_remote2 <= stretch(base_time_remote2, cfg6[FMC_SLOW_REMOTE2],
                                           cfg6[FMC_EXTRA_SLOW]);   // R03 R08
        end
    end

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    logic [2:0] sync_a;
    logic [2:0] sync_b;
    logic       scl_s;
    logic       sda_s;
    logic       scl_d;
    logic       sda_d;
    logic       standby_s;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            // idle levels: bus pins high, standby low, so release shows no edge
            sync_a    <= 3'b110;
            sync_b    <= 3'b110;
            standby_s <= 1'b0;
            scl_s     <= 1'b1;
            sda_s     <= 1'b1;
            scl_d     <= 1'b1;
            sda_d     <= 1'b1;
        end else begin
            sync_a    <= {scl_pin, sda_pin, standby_supply_pin};
            sync_b    <= sync_a;
            scl_s     <= sync_b[2];
            sda_s     <= sync_b[1];
            standby_s <= sync_b[0];
            scl_d     <= scl_s;
            sda_d     <= sda_s;
        end
    end

    // ----------------------------------------------------------------
    // core-voltage sleep sequence
    // ----------------------------------------------------------------
    fmc_state_t state;
    fmc_state_t next_state;
    wire        core_low = core_voltage_reading < core_voltage_low_limit;
    wire        sleep_cond = cfg6[FMC_CORE_SLEEP] && standby_s && core_low;

    always_comb begin
        next_state = state;
        unique case (state)
            FMC_ST_RUN:   if (sleep_cond) next_state = FMC_ST_SLEEP;       // R04
            FMC_ST_SLEEP: if (!core_low) next_state = FMC_ST_SPIN;         // R07
            FMC_ST_SPIN:  if (spinup_done) next_state = FMC_ST_RUN;
            default:      next_state = FMC_ST_RUN;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= FMC_ST_RUN;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            core_low_status_set      <= 1'b0;
            core_low_alert           <= 1'b0;
            processor_hot_monitor_en <= 1'b1;
            spinup_request           <= 1'b0;
        end else begin
            core_low_status_set <= state == FMC_ST_RUN && sleep_cond;          // R04
            core_low_alert      <= next_state == FMC_ST_SLEEP
                                   && core_low_alert_enable;                  // R05
            processor_hot_monitor_en <= next_state != FMC_ST_SLEEP;           // R06 R07
            // fans stay in spin-up until the fan logic reports it done
            spinup_request      <= next_state == FMC_ST_SPIN;                 // R07
        end
    end

    // ----------------------------------------------------------------
    // bus timeout
    // ----------------------------------------------------------------
    logic [FMC_TIMEOUT_W-1:0] idle_cnt;
    wire bus_activity = scl_s != scl_d || sda_s != sda_d;
    wire timeout_on   = !cfg7[FMC_TO_DIS];                      // R15

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            idle_cnt    <= '0;
            bus_release <= 1'b0;
        end else begin
            bus_release <= 1'b0;
            if (!timeout_on || !bus_addressed || bus_activity) begin
                idle_cnt <= '0;
            end else if (idle_cnt == FMC_TIMEOUT_W'(TIMEOUT_CYC)) begin
                // strictly more than the limit has passed: let go of the bus
                idle_cnt    <= '0;
                bus_release <= 1'b1;                            // R16
            end else begin
                idle_cnt <= idle_cnt + 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_enter_sleep;
        state == FMC_ST_RUN ##1 state == FMC_ST_SLEEP;
    endsequence

    sequence s_leave_sleep;
        state == FMC_ST_SLEEP ##1 state == FMC_ST_SPIN;
    endsequence

    chk_slow_remote1: assert property ( // R01
        cfg6[FMC_SLOW_REMOTE1] && !cfg6[FMC_EXTRA_SLOW] && $stable(cfg6)
        |=> smooth_time_remote1 == {1'b0, $past(base_time_remote1), 2'b00})
        else $error("remote-one smoothing not quadrupled");

    chk_slow_local: assert property ( // R02
        cfg6[FMC_SLOW_LOCAL] && !cfg6[FMC_EXTRA_SLOW]
        |=> smooth_time_local == {1'b0, $past(base_time_local), 2'b00})
        else $error("local smoothing not quadrupled");

    chk_slow_remote2: assert property ( // R03
        !cfg6[FMC_SLOW_REMOTE2] && !cfg6[FMC_EXTRA_SLOW]
        |=> smooth_time_remote2 == {3'b000, $past(base_time_remote2)})
        else $error("remote-two smoothing scaled without slow bit");

    chk_extra_stretch: assert property ( // R08
        cfg6[FMC_EXTRA_SLOW] && !cfg6[FMC_SLOW_LOCAL] && base_time_local == 16'h03e8
        |=> smooth_time_local == 19'h0056f)
        else $error("extra stretch not applied");

    chk_status_set: assert property ( // R04
        s_enter_sleep |-> core_low_status_set)
        else $error("status bit not set on core low");

    chk_alert_gate: assert property ( // R05
        core_low_alert |-> $past(core_low_alert_enable) && state == FMC_ST_SLEEP)
        else $error("alert raised without enable");

    chk_hot_off: assert property ( // R06
        state == FMC_ST_SLEEP |-> !processor_hot_monitor_en)
        else $error("processor-hot monitoring active in sleep");

    chk_wake_spinup: assert property ( // R07
        s_leave_sleep |-> processor_hot_monitor_en && spinup_request
        ##1 (spinup_request throughout (state == FMC_ST_SPIN)[*1]))
        else $error("no spin-up after recovery");

    chk_lock_hold: assert property ( // R09
        lock && reg_wr_en |=> $stable(cfg6)
        && cfg7[4:2] == $past(cfg7[4:2]) && cfg7[0] == $past(cfg7[0]))
        else $error("locked register changed");

    chk_full_speed_wr: assert property ( // R12
        wr7 |=> cfg7[FMC_FULL_SPEED] == $past(reg_wr_data[FMC_FULL_SPEED])
        ##1 all_fans_full_speed == $past(cfg7[FMC_FULL_SPEED]))
        else $error("full-speed bit not written");

    chk_hyst_follow: assert property ( // R10
        overtemp_hysteresis_en == !$past(cfg7[FMC_HYST_DIS]))
        else $error("hysteresis enable wrong");

    chk_reserved_zero: assert property ( // R18
        (cfg6 & ~FMC_CFG6_MASK) == 8'h00 && (cfg7 & ~FMC_CFG7_MASK) == 8'h00)
        else $error("reserved bit set");

    chk_timeout_off: assert property ( // R15
        cfg7[FMC_TO_DIS] |=> !bus_release)
        else $error("release while timeout disabled");

    chk_timeout_len: assert property ( // R16
        bus_release |-> $past(idle_cnt) == FMC_TIMEOUT_W'(TIMEOUT_CYC))
        else $error("release at wrong idle count");

    // slow bit set case for remote two; the clear case is covered above
    chk_remote2_slow: assert property ( // R03
        cfg6[FMC_SLOW_REMOTE2] && !cfg6[FMC_EXTRA_SLOW]
        |=> smooth_time_remote2 == {1'b0, $past(base_time_remote2), 2'b00})
        else $error("remote-two smoothing not quadrupled");

    chk_full_speed_out: assert property ( // R11
        all_fans_full_speed == $past(cfg7[FMC_FULL_SPEED]))
        else $error("full-speed output does not follow its bit");

    chk_spin_style_out: assert property ( // R14
        spinup_pulse_count_disable == $past(cfg7[FMC_SPIN_STYLE]))
        else $error("spin-up style output does not follow its bit");

    // sleep needs all three conditions in the cycle before the pulse
    chk_status_cause: assert property ( // R04
        core_low_status_set
        |-> $past(standby_s) && $past(cfg6[FMC_CORE_SLEEP]) && $past(core_low))
        else $error("status pulse without its conditions");

    chk_alert_follow: assert property ( // R05
        next_state == FMC_ST_SLEEP && core_low_alert_enable |=> core_low_alert)
        else $error("enabled alert missing in sleep");

    chk_sleep_hold: assert property ( // R06
        state == FMC_ST_SLEEP && core_low |=> state == FMC_ST_SLEEP)
        else $error("sleep left while core still low");

    // only the voltage ends sleep, only the fan logic ends spin-up
    chk_spin_end: assert property ( // R07
        state == FMC_ST_SPIN && spinup_done
        |=> state == FMC_ST_RUN && !spinup_request)
        else $error("spin-up not ended by the fan logic");

    // any bus pin edge restarts the count, so no release can follow it at once
    chk_release_idle: assert property ( // R16
        bus_activity |=> !bus_release)
        else $error("release right after bus activity");

endmodule

// ### tb/fmc_fan_model.sv
// Far-side model: fan logic that ends spin-up, and a bus host's two pins.
// Assumes the configuration block's 25 MHz clock and its active-low reset.
module fmc_fan_model #(
    parameter int SPIN_CYC = 4
) (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic spinup_request,
    input  wire logic bus_toggle,
    output logic      spinup_done,
    output logic      scl_pin,
    output logic      sda_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    int         spin_cnt;
    logic [1:0] div;
    // ----------------------------------------------------------------
    // spin-up ends a fixed time after the request
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            spin_cnt    <= 0;
            spinup_done <= 1'b0;
        end else begin
            spin_cnt    <= spinup_request ? spin_cnt + 1 : 0;
            spinup_done <= spinup_request && (spin_cnt == SPIN_CYC);
        end
    end
    // ----------------------------------------------------------------
    // pins sit at the pull-up level unless the host is clocking
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            div     <= 2'h0;
            scl_pin <= 1'b1;
            sda_pin <= 1'b1;
        end else begin
            div     <= bus_toggle ? div + 2'h1 : 2'h0;
            scl_pin <= !(bus_toggle && div[1]);
            // data falls only while the clock is low and rises on the same edge as the clock
            sda_pin <= !(bus_toggle && div[1] && div[0]);
        end
    end
endmodule

// ### tb/tb_top.sv
// Self-checking bench for the configuration pair 6 and 7.
// Assumes the byte register port, the fan model and a shortened bus timeout.
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import fmc_pkg::*;
    localparam int TO = 20;
    logic        clk = 0, rst_n = 0, wr_en = 0, rd_en = 0, lock = 0, standby = 0;
    logic        alert_en = 0, bus_addr = 0, bus_toggle = 0;
    logic [7:0]  addr = 0, wdata = 0, limit = 0, reading = 0, c6, c7, rd_data;
    logic [15:0] b_r1 = 0, b_lo = 0, b_r2 = 0;
    logic [18:0] s_r1, s_lo, s_r2;
    logic        hit, st_set, alert, hot_en, spin_req, hyst_en, full_spd, pwr_flag;
    logic        spin_dis, release_p, spin_done, scl, sda;
    int          fails = 0, checks_done = 0;

    always #20 clk = ~clk;

    fmc_config_six_seven #(.SMOOTH_W(16), .TIMEOUT_CYC(TO)) u_fmc_config_six_seven (
        .clk(clk), .rst_n(rst_n), .reg_addr(addr), .reg_wr_en(wr_en),
        .reg_wr_data(wdata), .reg_rd_en(rd_en), .reg_rd_data(rd_data), .reg_hit(hit),
        .lock(lock), .base_time_remote1(b_r1), .base_time_local(b_lo),
        .base_time_remote2(b_r2), .smooth_time_remote1(s_r1), .smooth_time_local(s_lo),
        .smooth_time_remote2(s_r2), .standby_supply_pin(standby),
        .core_voltage_reading(reading), .core_voltage_low_limit(limit),
        .core_low_alert_enable(alert_en), .spinup_done(spin_done),
        .core_low_status_set(st_set), .core_low_alert(alert),
        .processor_hot_monitor_en(hot_en), .spinup_request(spin_req),
        .overtemp_hysteresis_en(hyst_en), .all_fans_full_speed(full_spd),
        .power_display_flag(pwr_flag), .spinup_pulse_count_disable(spin_dis),
        .scl_pin(scl), .sda_pin(sda), .bus_addressed(bus_addr), .bus_release(release_p));

    fmc_fan_model #(.SPIN_CYC(4)) u_fmc_fan_model (
        .clk(clk), .rst_n(rst_n), .spinup_request(spin_req), .bus_toggle(bus_toggle),
        .spinup_done(spin_done), .scl_pin(scl), .sda_pin(sda));

    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    function automatic logic [18:0] exp_smooth(logic [15:0] b, logic s, logic e);
        logic [18:0] t;
        logic [28:0] p;
        t = s ? {1'b0, b, 2'b00} : {3'b000, b};
        p = 29'(t) * 29'(FMC_EXTRA_NUM);
        if (e) t = t + 19'(p >> FMC_EXTRA_SHIFT);
        return t;
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic finish_test;
        $display("checks %0d, mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        addr = a;
        wdata = d;
        wr_en = 1'b1;
        @(negedge clk);
        wr_en = 1'b0;
        @(negedge clk);
        // reference copy follows the lock: only full speed stays writable
        if (a == FMC_CFG6_ADDR && !lock) c6 = d & FMC_CFG6_MASK;
        if (a == FMC_CFG7_ADDR && !lock) c7 = d & FMC_CFG7_MASK;
        if (a == FMC_CFG7_ADDR && lock) c7[FMC_FULL_SPEED] = d[FMC_FULL_SPEED];
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic h);
        @(negedge clk);
        addr = a;
        rd_en = 1'b1;
        @(negedge clk);
        rd_en = 1'b0;
        d = rd_data;
        h = hit;
    endtask

    task automatic check_regs;
        logic [7:0] d;
        logic       h;
        rd(FMC_CFG6_ADDR, d, h);
        check(d, c6);
        check(h, 1'b1);
        rd(FMC_CFG7_ADDR, d, h);
        check(d, c7);
        check(hyst_en, !c7[FMC_HYST_DIS]);
        check(full_spd, c7[FMC_FULL_SPEED]);
        check(pwr_flag, c7[FMC_PWR_DISPLAY]);
        check(spin_dis, c7[FMC_SPIN_STYLE]);
        check(s_r1, exp_smooth(b_r1, c6[FMC_SLOW_REMOTE1], c6[FMC_EXTRA_SLOW]));
        check(s_lo, exp_smooth(b_lo, c6[FMC_SLOW_LOCAL], c6[FMC_EXTRA_SLOW]));
        check(s_r2, exp_smooth(b_r2, c6[FMC_SLOW_REMOTE2], c6[FMC_EXTRA_SLOW]));
    endtask

    task automatic count_pulses(input int cyc, ref logic sig, output int n);
        n = 0;
        repeat (cyc) begin
            @(negedge clk);
            n += int'(sig);
        end
    endtask

    initial begin
        #(40 * 5000);
        fails++;
        finish_test;
    end

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        logic [7:0] d;
        logic       h;
        int         n;
        void'($urandom(32'h0ba0));
        repeat (16) @(negedge clk);
        rst_n = 1'b1;
        c6 = FMC_CFG6_RESET;
        c7 = FMC_CFG7_RESET;
        check_regs;
        rd(8'h20, d, h);
        check(d, 8'h00);
        check(h, 1'b0);
        // first pass writes all ones to register 6 and the remote-one and local bases, the last four run locked
        for (int i = 0; i < 10; i++) begin
            lock = (i > 5);
            b_r1 = (i == 0) ? 16'hffff : 16'($urandom);
            b_lo = (i == 0) ? 16'hffff : 16'($urandom);
            b_r2 = 16'($urandom);
            wr(FMC_CFG6_ADDR, (i == 0) ? 8'hff : 8'($urandom));
            wr(FMC_CFG7_ADDR, 8'($urandom) & 8'h1f);
            check_regs;
        end
        lock = 1'b0;
        // corner: 1000 cycles stretched by 401/1024, rounded down
        b_lo = 16'h03e8;
        wr(FMC_CFG6_ADDR, 8'h80);
        check(s_lo, 19'h0056f);
        wr(FMC_CFG7_ADDR, 8'h00);
        wr(FMC_CFG6_ADDR, 8'h00);
        limit = 8'h80;
        reading = 8'h10;
        standby = 1'b1;
        alert_en = 1'b1;
        count_pulses(12, st_set, n);
        check(n, 0);
        check(hot_en, 1'b1);
        reading = 8'h90;
        wr(FMC_CFG6_ADDR, 8'h40);
        reading = 8'h10;
        count_pulses(12, st_set, n);
        check(n, 1);
        check(alert, 1'b1);
        check(hot_en, 1'b0);
        alert_en = 1'b0;
        repeat (2) @(negedge clk);
        check(alert, 1'b0);
        reading = 8'h90;
        n = 0;
        while (spin_req !== 1'b1 && n < 10) begin
            @(negedge clk);
            n++;
        end
        check(spin_req, 1'b1);
        check(hot_en, 1'b1);
        n = 0;
        while (spin_req !== 1'b0 && n < 20) begin
            @(negedge clk);
            n++;
        end
        check(spin_req, 1'b0);
        standby = 1'b0;
        bus_addr = 1'b1;
        bus_toggle = 1'b1;
        count_pulses(60, release_p, n);
        check(n, 0);
        bus_toggle = 1'b0;
        count_pulses(TO + 15, release_p, n);
        check(n, 1);
        wr(FMC_CFG7_ADDR, 8'h10);
        count_pulses(60, release_p, n);
        check(n, 0);
        bus_addr = 1'b0;
        finish_test;
    end
endmodule
